// [verilog/bme_top.sv]
/*
 * Break and monitor entry logic: address breakpoint with its register
 * file on classic Wishbone, break-time controls for other modules, and
 * monitor mode entry with the single-wire serial handshake.
 * Assumes the CPU flags real fetch addresses and reports the end of the
 * break routine; the serial pin is wired-OR with an external pullup.
 */
// Chosen here: the Wishbone interface to the registers and the register offsets.
//
// Notes on behaviour
// R1: Enabled break on 16-bit fetch address match.
// R2: Match sets active flag; writing one breaks.
// R3: Unchanged address after clear gives no rebreak.
// R4: Address held as high and low bytes.
// R5: Flag clearing in break needs enable bit.
// R6: Timer counter halted during break.
// R7: Monitor break with hold bit stops watchdog.
// R8: Reset clears the watchdog hold bit.
// R9: Flag shows break ended wait mode.
// R10: No break in wait or stop; the code blocks only the address match break, a software break still occurs.
// R11: Monitor mode latched at reset release.
// R12: Break sent only after eight security bytes; the code also echoes a received break before the eighth byte.
// R13: Bit period is 256 or 335 cycles.
// R14: Host supplies clock and mode pin levels.
// R15: Serial pin wired-OR, never driven high.
// R16: Internal oscillator once test voltage removed.
// R17: Break vectors through user or monitor pair.
// R18: Received break: release two bits, echo.
`timescale 1ns/1ps
module bme_top (
    // Clock and reset.
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Wishbone slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // CPU side.
    input wire logic [15:0] fetch_addr_i,
    input wire logic fetch_valid_i,
    input wire logic wait_mode_i,
    input wire logic stop_mode_i,
    input wire logic emulation_mode_i,
    input wire logic break_end_i,
    output logic break_req_o,
    output logic [15:0] break_vector_o,
    output logic break_state_o,
    // Controls for other modules.
    output logic flag_clear_allow_o,
    output logic timer_halt_o,
    output logic watchdog_disable_o,
    // Mode pins.
    input wire logic test_high_voltage_i,
    input wire logic mode_select_pin0_i,
    input wire logic mode_select_pin1_i,
    output logic monitor_mode_o,
    output logic osc_internal_o,
    // Serial pin.
    input wire logic monitor_serial_pin_i,
    output logic monitor_serial_pin_o,
    output logic monitor_serial_pin_oe_o
);
    typedef enum logic [2:0] {
        BME_SEC_WAIT,
        BME_IDLE,
        BME_RECEIVE,
        BME_GAP,
        BME_SEND_BREAK
    } bme_ser_e;

    logic match_enable;
    logic active_flag;
    logic [7:0] address_high;
    logic [7:0] address_low;
    logic watchdog_hold;
    logic wait_exit_flag;
    logic flag_clear_enable;
    logic rearm_needed;
    logic break_state;
    logic bus_take;
    logic bus_write;
    logic [7:0] wdata;
    logic addr_match;
    logic sw_break;
    logic next_break;
    logic rst_q;
    logic tst_s;
    logic ms0_s;
    logic ms1_s;
    logic ser_s;
    logic ser_q;
    logic secured;
    logic [3:0] sec_count;
    logic [3:0] bit_count;
    logic [9:0] shift;
    logic [7:0] rx_byte;
    logic [8:0] divisor;
    logic tick;
    logic timer_start;
    logic timer_half;
    logic [7:0] read_byte;
    bme_ser_e ser_state;
    bme_ser_e next_ser_state;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    bme_sync2 u_sync_tst (
        .clk_i(core_clk_i),
        .async_i(test_high_voltage_i),
        .sync_o(tst_s)
    );
    bme_sync2 u_sync_ms0 (
        .clk_i(core_clk_i),
        .async_i(mode_select_pin0_i),
        .sync_o(ms0_s)
    );
    bme_sync2 u_sync_ms1 (
        .clk_i(core_clk_i),
        .async_i(mode_select_pin1_i),
        .sync_o(ms1_s)
    );
    bme_sync2 u_sync_ser (
        .clk_i(core_clk_i),
        .async_i(monitor_serial_pin_i),
        .sync_o(ser_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // Wishbone slave.

    assign bus_take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_write = bus_take && wb_we_i && wb_sel_i[0];
    assign wdata = wb_dat_i[7:0];

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_take;
        end
    end

    always_comb begin
        read_byte = 8'h00;
        unique case (wb_adr_i)
            bme_pkg::OFS_STATUS_CONTROL: begin
                read_byte[bme_pkg::BIT_MATCH_ENABLE] = match_enable;
                read_byte[bme_pkg::BIT_ACTIVE_FLAG] = active_flag;
            end
            bme_pkg::OFS_ADDRESS_HIGH: read_byte = address_high;
            bme_pkg::OFS_ADDRESS_LOW: read_byte = address_low;
            bme_pkg::OFS_AUXILIARY: begin
                read_byte[bme_pkg::BIT_WATCHDOG_HOLD] = watchdog_hold;
            end
            bme_pkg::OFS_WAIT_STATUS: begin
                read_byte[bme_pkg::BIT_WAIT_EXIT] = wait_exit_flag;
            end
            bme_pkg::OFS_FLAG_CONTROL: begin
                read_byte[bme_pkg::BIT_FLAG_CLEAR_EN] = flag_clear_enable;
            end
            bme_pkg::OFS_MONITOR_STATUS: begin
                read_byte[bme_pkg::BIT_MON_MODE] = monitor_mode_o;
                read_byte[bme_pkg::BIT_MON_INT_OSC] = osc_internal_o;
                read_byte[bme_pkg::BIT_MON_SECURED] = secured;
            end
            bme_pkg::OFS_MONITOR_DATA: read_byte = rx_byte;
            default: read_byte = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h00000000;
        end else if (bus_take) begin
            wb_dat_o <= {24'h000000, read_byte};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Break registers.

    // R1 enable bit
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            match_enable <= 1'b0;
        end else if (bus_write
                && wb_adr_i == bme_pkg::OFS_STATUS_CONTROL) begin
            match_enable <= wdata[bme_pkg::BIT_MATCH_ENABLE];
        end
    end

    // R4 address byte registers
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            address_high <= bme_pkg::RST_BYTE;
            address_low <= bme_pkg::RST_BYTE;
        end else if (bus_write) begin
            if (wb_adr_i == bme_pkg::OFS_ADDRESS_HIGH) begin
                address_high <= wdata;
            end
            if (wb_adr_i == bme_pkg::OFS_ADDRESS_LOW) begin
                address_low <= wdata;
            end
        end
    end

    // R8 hold bit reset
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            watchdog_hold <= 1'b0;
        end else if (bus_write && wb_adr_i == bme_pkg::OFS_AUXILIARY) begin
            watchdog_hold <= wdata[bme_pkg::BIT_WATCHDOG_HOLD];
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            flag_clear_enable <= 1'b0;
        end else if (bus_write
                && wb_adr_i == bme_pkg::OFS_FLAG_CONTROL) begin
            flag_clear_enable <= wdata[bme_pkg::BIT_FLAG_CLEAR_EN];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Break detection.

    // R1 R10 match on real fetches only
    assign addr_match = match_enable && fetch_valid_i && !wait_mode_i
        && !stop_mode_i && fetch_addr_i == {address_high, address_low};

    // R2 software break
    assign sw_break = bus_write && wb_adr_i == bme_pkg::OFS_STATUS_CONTROL
        && wdata[bme_pkg::BIT_ACTIVE_FLAG];

    // R3 no rebreak at same address
    assign next_break = sw_break
        || (addr_match && !rearm_needed && !break_state);

    // R3 rearm on any write to either address byte, even with the same value
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rearm_needed <= 1'b0;
        end else if (next_break && !sw_break) begin
            rearm_needed <= 1'b1;
        end else if (bus_write && (wb_adr_i == bme_pkg::OFS_ADDRESS_HIGH
                || wb_adr_i == bme_pkg::OFS_ADDRESS_LOW)) begin
            rearm_needed <= 1'b0;
        end
    end

    // R2 active flag, set wins
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            active_flag <= 1'b0;
        end else if (next_break) begin
            active_flag <= 1'b1;
        end else if (bus_write
                && wb_adr_i == bme_pkg::OFS_STATUS_CONTROL) begin
            active_flag <= 1'b0;
        end
    end

    // R17 force the interrupt
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            break_req_o <= 1'b0;
        end else begin
            break_req_o <= next_break;
        end
    end

    // R17 vector pair
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            break_vector_o <= bme_pkg::VEC_USER_BREAK;
        end else begin
            break_vector_o <= monitor_mode_o ? bme_pkg::VEC_MONITOR_BREAK
                : bme_pkg::VEC_USER_BREAK;
        end
    end

    // The routine end only counts once the request has been raised.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            break_state <= 1'b0;
        end else if (break_req_o) begin
            break_state <= 1'b1;
        end else if (break_end_i) begin
            break_state <= 1'b0;
        end
    end

    // R9 wait exit flag
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            wait_exit_flag <= 1'b0;
        end else if (next_break && wait_mode_i && emulation_mode_i) begin
            wait_exit_flag <= 1'b1;
        end else if (bus_write && wb_adr_i == bme_pkg::OFS_WAIT_STATUS
                && !wdata[bme_pkg::BIT_WAIT_EXIT]) begin
            wait_exit_flag <= 1'b0;
        end
    end

    assign break_state_o = break_state;
    // R5 flag protection
    assign flag_clear_allow_o = !break_state || flag_clear_enable;
    // R6 timer stop
    assign timer_halt_o = break_state;
    // R7 watchdog hold
    assign watchdog_disable_o = break_state && monitor_mode_o
        && watchdog_hold;

    ////////////////////////////////////////////////////////////////////////
    // Monitor mode entry.

    // R11 latch at reset release
    always_ff @(posedge core_clk_i) begin
        rst_q <= rst_i;
        if (rst_q && !rst_i) begin
            monitor_mode_o <= tst_s && ms0_s && !ms1_s;
        end else if (rst_i) begin
            monitor_mode_o <= 1'b0;
        end
    end

    // R16 internal oscillator
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            osc_internal_o <= 1'b0;
        end else if (monitor_mode_o && !tst_s) begin
            osc_internal_o <= 1'b1;
        end
    end

    // R13 bit period
    assign divisor = osc_internal_o ? bme_pkg::DIV_INT_OSC
        : bme_pkg::DIV_EXT_OSC;

    bme_bit_timer u_bit_timer (
        .clk_i(core_clk_i),
        .rst_i(rst_i),
        .start_i(timer_start),
        .half_i(timer_half),
        .divisor_i(divisor),
        .tick_o(tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Serial monitor unit.

    always_comb begin
        next_ser_state = ser_state;
        timer_start = 1'b0;
        timer_half = 1'b0;
        unique case (ser_state)
            BME_SEC_WAIT, BME_IDLE: begin
                if (monitor_mode_o && ser_q && !ser_s) begin
                    next_ser_state = BME_RECEIVE;
                    timer_start = 1'b1;
                    timer_half = 1'b1;
                end
            end
            BME_RECEIVE: begin
                if (tick && bit_count == bme_pkg::FRAME_BITS - 4'h1) begin
                    // R18 break seen
                    if (!ser_s && shift[9:1] == 9'h000) begin
                        next_ser_state = BME_GAP;
                        timer_start = 1'b1;
                    // R12 eighth byte done
                    end else if (!secured && sec_count
                            == bme_pkg::SECURITY_BYTES - 4'h1) begin
                        next_ser_state = BME_SEND_BREAK;
                        timer_start = 1'b1;
                    end else begin
                        next_ser_state = secured ? BME_IDLE : BME_SEC_WAIT;
                    end
                end
            end
            BME_GAP: begin
                if (tick && bit_count == bme_pkg::ECHO_GAP_BITS - 4'h1) begin
                    next_ser_state = BME_SEND_BREAK;
                end
            end
            BME_SEND_BREAK: begin
                if (tick && bit_count == bme_pkg::BREAK_BITS - 4'h1) begin
                    next_ser_state = secured ? BME_IDLE : BME_SEC_WAIT;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            ser_state <= BME_SEC_WAIT;
            ser_q <= 1'b1;
        end else begin
            ser_state <= next_ser_state;
            ser_q <= ser_s;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i || next_ser_state != ser_state) begin
            bit_count <= 4'h0;
        end else if (tick) begin
            bit_count <= bit_count + 4'h1;
        end
    end

    // Bits arrive low first, so the byte sits above the start bit.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            shift <= 10'h000;
            rx_byte <= 8'h00;
        end else if (ser_state == BME_RECEIVE && tick) begin
            shift <= {ser_s, shift[9:1]};
            if (bit_count == bme_pkg::FRAME_BITS - 4'h1) begin
                rx_byte <= shift[9:2];
            end
        end
    end

    // R12 count security bytes
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            sec_count <= 4'h0;
            secured <= 1'b0;
        end else if (ser_state == BME_RECEIVE && !secured && tick
                && bit_count == bme_pkg::FRAME_BITS - 4'h1) begin
            sec_count <= sec_count + 4'h1;
            if (sec_count == bme_pkg::SECURITY_BYTES - 4'h1) begin
                secured <= 1'b1;
            end
        end
    end

    // R15 only ever pull low
    assign monitor_serial_pin_o = 1'b0;

    // R18 release during gap, then drive break
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            monitor_serial_pin_oe_o <= 1'b0;
        end else begin
            monitor_serial_pin_oe_o <= next_ser_state == BME_SEND_BREAK;
        end
    end
endmodule : bme_top

// [common/bme_pkg.sv]
/*
 * Constants shared by the break and monitor entry block: register byte
 * offsets, field positions, reset values, vectors and serial timing.
 * Assumes a 32-bit classic Wishbone bus with byte addressing.
 */
package bme_pkg;
    // Register byte offsets on the Wishbone bus.
    localparam logic [7:0] OFS_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_ADDRESS_HIGH = 8'h04;
    localparam logic [7:0] OFS_ADDRESS_LOW = 8'h08;
    localparam logic [7:0] OFS_AUXILIARY = 8'h0c;
    localparam logic [7:0] OFS_WAIT_STATUS = 8'h10;
    localparam logic [7:0] OFS_FLAG_CONTROL = 8'h14;
    localparam logic [7:0] OFS_MONITOR_STATUS = 8'h18;
    localparam logic [7:0] OFS_MONITOR_DATA = 8'h1c;

    // Field positions.
    localparam int BIT_MATCH_ENABLE = 7;
    localparam int BIT_ACTIVE_FLAG = 6;
    localparam int BIT_WATCHDOG_HOLD = 0;
    localparam int BIT_WAIT_EXIT = 1;
    localparam int BIT_FLAG_CLEAR_EN = 7;
    localparam int BIT_MON_MODE = 0;
    localparam int BIT_MON_INT_OSC = 1;
    localparam int BIT_MON_SECURED = 2;

    // Reset values.
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_ADDRESS = 16'h0000;

    // Break vectors for user and monitor mode.
    localparam logic [15:0] VEC_USER_BREAK = 16'hfffc;
    localparam logic [15:0] VEC_MONITOR_BREAK = 16'hfefc;

    // Serial timing: bit periods in bus cycles, frame, break and gap lengths in bits, security byte count.
    localparam logic [8:0] DIV_EXT_OSC = 9'h100;
    localparam logic [8:0] DIV_INT_OSC = 9'h14f;
    localparam logic [3:0] FRAME_BITS = 4'ha;
    localparam logic [3:0] BREAK_BITS = 4'ha;
    localparam logic [3:0] ECHO_GAP_BITS = 4'h2;
    localparam logic [3:0] SECURITY_BYTES = 4'h8;
endpackage : bme_pkg

// [verilog/bme_sync2.sv]
/*
 * Two flip-flop synchroniser for one asynchronous level.
 * Assumes the input is a pin level that may change at any time.
 */
`timescale 1ns/1ps
module bme_sync2 (
    // Clock.
    input wire logic clk_i,
    // Level in and out.
    input wire logic async_i,
    output logic sync_o
);
    logic meta;

    // Left without reset so a strap is seen on the first edge after release.
    always_ff @(posedge clk_i) begin
        meta <= async_i;
        sync_o <= meta;
    end
endmodule : bme_sync2

// [verilog/bme_bit_timer.sv]
/*
 * Serial bit timer: ticks once a bit period, or after half a period when
 * started with the half flag, then every full period.
 * Assumes a divisor of at least two cycles.
 */
`timescale 1ns/1ps
module bme_bit_timer (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Control.
    input wire logic start_i,
    input wire logic half_i,
    input wire logic [8:0] divisor_i,
    // Tick.
    output logic tick_o
);
    logic [8:0] count;

    assign tick_o = (count == 9'h001);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count <= 9'h000;
        end else if (start_i) begin
            count <= half_i ? {1'b0, divisor_i[8:1]} : divisor_i;
        end else if (tick_o) begin
            count <= divisor_i;
        end else if (count != 9'h000) begin
            count <= count - 9'h001;
        end
    end
endmodule : bme_bit_timer

// [tb/bme_top_monitor.sv]
/*
 * Concurrent checks on the ports of the break and monitor entry block.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module bme_monitor (
    // Clock and reset.
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Bus and CPU side.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic wb_ack_o,
    input wire logic wait_mode_i,
    input wire logic stop_mode_i,
    input wire logic break_end_i,
    input wire logic break_req_o,
    input wire logic [15:0] break_vector_o,
    input wire logic break_state_o,
    // Controls and pins.
    input wire logic flag_clear_allow_o,
    input wire logic timer_halt_o,
    input wire logic watchdog_disable_o,
    input wire logic monitor_mode_o,
    input wire logic monitor_serial_pin_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////
    bus_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not one cycle");
    break_state_a: assert property (
        break_req_o |=> break_state_o) else $error("break state missing");
    break_end_a: assert property (
        break_state_o && break_end_i && !break_req_o |=> !break_state_o)
        else $error("break state not ended");
    low_power_a: assert property (
        (wait_mode_i || stop_mode_i) && !(wb_cyc_i && wb_stb_i && wb_we_i)
        |=> !break_req_o) else $error("break in low power mode");
    timer_halt_a: assert property (
        timer_halt_o == break_state_o) else $error("timer halt wrong");
    flag_clear_a: assert property (
        !break_state_o |-> flag_clear_allow_o) else $error("flag lock");
    watchdog_a: assert property (
        watchdog_disable_o |-> break_state_o && monitor_mode_o)
        else $error("watchdog held outside monitor break");
    vector_a: assert property (
        break_req_o |-> break_vector_o == (monitor_mode_o ?
        bme_pkg::VEC_MONITOR_BREAK : bme_pkg::VEC_USER_BREAK))
        else $error("wrong break vector");
    mode_hold_a: assert property (
        !$past(rst_i) && !$past(rst_i, 2) |-> $stable(monitor_mode_o))
        else $error("monitor mode changed");
    pin_low_a: assert property (
        monitor_serial_pin_o == 1'b0) else $error("serial pin driven");
endmodule : bme_monitor

bind bme_top bme_monitor u_monitor (.*);

// [tb/bme_host_model.sv]
/*
 * Host side of the monitor link: entry pin levels and a wired-OR serial
 * driver that also measures how long the device holds the line low.
 * Assumes the bench forms the line level with a pullup.
 */
`timescale 1ns/1ps
module bme_host_model (
    // Clock.
    input wire logic clk_i,
    // Session control.
    input wire logic release_i,
    input wire logic swap_i,
    // Pins.
    input wire logic line_i,
    output logic pull_o,
    output logic tst_o,
    output logic ms0_o,
    output logic ms1_o
);
    int low_run = 0;
    int last_run = 0;
    ////////////////////////////////////////
    // test voltage level.
    assign tst_o = !release_i;
    assign ms0_o = !swap_i;
    assign ms1_o = swap_i;
    always @(posedge clk_i) begin
        if (!line_i && !pull_o) begin
            low_run++;
        end else if (low_run != 0) begin
            last_run = low_run;
            low_run = 0;
        end
    end
    // pulls low only, so it never fights the device.
    initial pull_o = 1'b0;
    task automatic send_frame(input logic [9:0] f, input int per);
        for (int i = 0; i < 10; i++) begin
            pull_o <= !f[i];
            repeat (per) @(posedge clk_i);
        end
        if (!f[9]) begin
            pull_o <= 1'b0;
        end
    endtask : send_frame
endmodule : bme_host_model

// [tb/bme_top_tb.sv]
/*
 * Register, break and monitor link tests for the break and monitor
 * entry block. Assumes the host model and the bound checker.
 */
`timescale 1ns/1ps
module bme_top_tb;
    localparam logic [7:0] a_sc = bme_pkg::OFS_STATUS_CONTROL;
    localparam logic [7:0] a_ah = bme_pkg::OFS_ADDRESS_HIGH;
    localparam logic [7:0] a_al = bme_pkg::OFS_ADDRESS_LOW;
    localparam logic [7:0] a_ax = bme_pkg::OFS_AUXILIARY;
    localparam logic [7:0] a_ws = bme_pkg::OFS_WAIT_STATUS;
    localparam logic [7:0] a_fc = bme_pkg::OFS_FLAG_CONTROL;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic [15:0] fetch_addr_i = 16'h0000, break_vector_o;
    logic fetch_valid_i = 1'b0, wait_mode_i = 1'b0, stop_mode_i = 1'b0;
    logic emulation_mode_i = 1'b0, break_end_i = 1'b0;
    logic break_req_o, break_state_o, flag_clear_allow_o, timer_halt_o;
    logic watchdog_disable_o, monitor_mode_o, osc_internal_o;
    logic test_high_voltage_i, mode_select_pin0_i, mode_select_pin1_i;
    logic monitor_serial_pin_o, monitor_serial_pin_oe_o, host_pull;
    logic rel = 1'b1, swap = 1'b0;
    logic [7:0] rd;
    wire monitor_serial_pin_i;
    int err_total = 0, n_checks = 0, n_breq = 0;
    // The pullup wins unless some party pulls the line low.
    assign monitor_serial_pin_i = !monitor_serial_pin_oe_o && !host_pull;
    bme_top dut (.*);
    bme_host_model host (.clk_i(core_clk_i), .release_i(rel),
        .swap_i(swap), .line_i(monitor_serial_pin_i), .pull_o(host_pull),
        .tst_o(test_high_voltage_i), .ms0_o(mode_select_pin0_i),
        .ms1_o(mode_select_pin1_i));
    initial forever #5 core_clk_i = !core_clk_i;
    always @(posedge core_clk_i) if (break_req_o === 1'b1) n_breq++;
    ////////////////////////////////////////
    task automatic test_done;
        if (err_total == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : test_done
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic wb(input logic we, input logic [7:0] a,
        input logic [7:0] d);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'hf;
        wb_dat_i <= {24'h000000, d};
        @(posedge core_clk_i);
        while (wb_ack_o !== 1'b1 && n < 20) begin
            @(posedge core_clk_i);
            n++;
        end
        if (n == 20) err_total++;
        rd = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge core_clk_i);
    endtask : wb
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h00);
        chk({8'h00, rd}, {8'h00, e});
    endtask : rdchk
    task automatic fetch(input logic [15:0] a);
        fetch_addr_i <= a;
        fetch_valid_i <= 1'b1;
        @(posedge core_clk_i);
        fetch_valid_i <= 1'b0;
        repeat (3) @(posedge core_clk_i);
    endtask : fetch
    task automatic end_break;
        wb(1'b1, a_sc, 8'h80);
        break_end_i <= 1'b1;
        @(posedge core_clk_i);
        break_end_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
    endtask : end_break
    task automatic do_reset;
        rst_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge core_clk_i);
    endtask : do_reset
    task automatic wait_run;
        int n;
        n = 0;
        while (host.last_run == 0 && n < 6000) begin
            @(posedge core_clk_i);
            n++;
        end
    endtask : wait_run
    ////////////////////////////////////////
    initial begin
        repeat (60000) @(posedge core_clk_i);
        err_total++;
        test_done();
    end
    initial begin
        do_reset();
        chk(16'(monitor_mode_o), 16'h0000);
        for (int i = 0; i < 6; i++) rdchk(8'(i * 4), 8'h00);
        rdchk(8'h20, 8'h00);
        wb(1'b1, a_ah, 8'h12);
        wb(1'b1, a_al, 8'h34);
        rdchk(a_ah, 8'h12);
        rdchk(a_al, 8'h34);
        fetch(16'h1234);
        chk(16'(n_breq), 16'h0000);
        wb(1'b1, a_sc, 8'h80);
        fetch(16'h1235);
        chk(16'(n_breq), 16'h0000);
        fetch(16'h1234);
        chk(16'(n_breq), 16'h0001);
        rdchk(a_sc, 8'hc0);
        chk(16'(timer_halt_o), 16'h0001);
        chk(16'(flag_clear_allow_o), 16'h0000);
        wb(1'b1, a_fc, 8'h80);
        chk(16'(flag_clear_allow_o), 16'h0001);
        chk(16'(watchdog_disable_o), 16'h0000);
        end_break();
        chk(16'(break_state_o), 16'h0000);
        rdchk(a_sc, 8'h80);
        fetch(16'h1234);
        chk(16'(n_breq), 16'h0001);
        wb(1'b1, a_al, 8'h34);
        fetch(16'h1234);
        chk(16'(n_breq), 16'h0002);
        end_break();
        wb(1'b1, a_al, 8'h34);
        wait_mode_i <= 1'b1;
        emulation_mode_i <= 1'b1;
        fetch(16'h1234);
        chk(16'(n_breq), 16'h0002);
        wait_mode_i <= 1'b0;
        stop_mode_i <= 1'b1;
        fetch(16'h1234);
        chk(16'(n_breq), 16'h0002);
        stop_mode_i <= 1'b0;
        wait_mode_i <= 1'b1;
        wb(1'b1, a_sc, 8'hc0);
        chk(16'(n_breq), 16'h0003);
        rdchk(a_ws, 8'h02);
        wb(1'b1, a_ws, 8'h00);
        rdchk(a_ws, 8'h00);
        wait_mode_i <= 1'b0;
        end_break();
        rel <= 1'b0;
        do_reset();
        chk(16'(monitor_mode_o), 16'h0001);
        chk(16'(osc_internal_o), 16'h0000);
        swap <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        chk(16'(monitor_mode_o), 16'h0001);
        rdchk(bme_pkg::OFS_MONITOR_STATUS, 8'h01);
        wb(1'b1, a_ax, 8'h01);
        rdchk(a_ax, 8'h01);
        wb(1'b1, a_sc, 8'h40);
        chk(16'(watchdog_disable_o), 16'h0001);
        end_break();
        for (int i = 0; i < 7; i++) begin
            host.send_frame({1'b1, 8'(i + 1), 1'b0}, 256);
        end
        repeat (600) @(posedge core_clk_i);
        chk(16'(host.last_run), 16'h0000);
        host.send_frame({1'b1, 8'h08, 1'b0}, 256);
        wait_run();
        chk(16'(host.last_run), 16'(10 * bme_pkg::DIV_EXT_OSC));
        rdchk(bme_pkg::OFS_MONITOR_STATUS, 8'h05);
        rdchk(bme_pkg::OFS_MONITOR_DATA, 8'h08);
        rel <= 1'b1;
        repeat (8) @(posedge core_clk_i);
        chk(16'(osc_internal_o), 16'h0001);
        host.last_run = 0;
        host.send_frame(10'h000, 335);
        wait_run();
        chk(16'(host.last_run), 16'(10 * bme_pkg::DIV_INT_OSC));
        test_done();
    end
endmodule : bme_top_tb
